// file: core/srs_regs.sv
// Register bank: command, results, main status, captured status copy, serial number.
// Assumes single-cycle events from same-clock logic; framing and checksum live upstream.
`timescale 1ns/1ps
module srs_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] start_addr_i,
    input wire logic byte_wr_i,
    input wire logic [7:0] wr_byte_i,
    input wire logic byte_rd_i,
    output logic [7:0] rd_byte_o,
    input wire srs_pkg::srs_result_type result_i,
    input wire srs_pkg::srs_cond_type cond_i,
    input wire logic nvm_crc_ok_i,
    input wire logic reload_done_i,
    input wire logic [15:0] serial_lo_i,
    input wire logic [15:0] serial_hi_i,
    output logic sleep_o,
    output logic reload_o,
    output logic nvm_check_o,
    output logic [15:0] temperature_o,
    output logic [15:0] pressure_o
);
    // ==========================================================
    // Byte sequencing
    // ==========================================================
    logic [7:0] word_addr;
    logic word_wr;
    logic word_rd;
    logic [15:0] wr_word;
    logic [15:0] rd_word;

    srs_word_serdes u_serdes (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start_i),
        .start_addr_i(start_addr_i),
        .byte_wr_i(byte_wr_i),
        .wr_byte_i(wr_byte_i),
        .byte_rd_i(byte_rd_i),
        .rd_word_i(rd_word),
        .rd_byte_o(rd_byte_o),
        .word_addr_o(word_addr),
        .word_wr_o(word_wr),
        .word_rd_o(word_rd),
        .wr_word_o(wr_word)
    );

    // ==========================================================
    // Power state
    // ==========================================================
    srs_pkg::srs_power_type state_r;
    srs_pkg::srs_power_type state_nxt;
    logic [4:0] reload_cnt_r;
    logic crc_bad_r;
    logic reload_end;

    // Only status and command accept writes; other addresses fall through [R1]
    wire cmd_wr = word_wr && (word_addr == srs_pkg::ADDR_CMD);
    wire stat_wr = word_wr && (word_addr == srs_pkg::ADDR_STAT);
    wire cmd_sleep = cmd_wr && (wr_word == srs_pkg::CMD_SLEEP);  // [R2]
    wire cmd_reset = cmd_wr && (wr_word == srs_pkg::CMD_RESET);  // [R3]
    // Other command codes match neither decode and change nothing [R22]

    // Reload lasts a minimum count so the outside loader sees the request
    assign reload_end = reload_done_i && (reload_cnt_r == 5'(srs_pkg::RELOAD_CYCLES - 1));

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            srs_pkg::SRS_RELOAD: begin
                if (reload_end) begin
                    state_nxt = srs_pkg::SRS_RUN;
                end
            end
            srs_pkg::SRS_RUN: begin
                if (cmd_reset) begin
                    state_nxt = srs_pkg::SRS_RELOAD;  // [R3]
                end else if (cmd_sleep) begin
                    state_nxt = srs_pkg::SRS_SLEEP;  // [R2]
                end
            end
            srs_pkg::SRS_SLEEP: begin
                // Only reset wakes the device; sleep exits via the power-up path
                if (cmd_reset) begin
                    state_nxt = srs_pkg::SRS_RELOAD;  // [R3]
                end
            end
            default: state_nxt = srs_pkg::SRS_RELOAD;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= srs_pkg::SRS_RELOAD;
            reload_cnt_r <= 5'h00;
            crc_bad_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r != srs_pkg::SRS_RELOAD || state_nxt != srs_pkg::SRS_RELOAD) begin
                reload_cnt_r <= 5'h00;
            end else if (reload_cnt_r != 5'(srs_pkg::RELOAD_CYCLES - 1)) begin
                reload_cnt_r <= reload_cnt_r + 5'h01;
            end
            if (reload_end) begin
                crc_bad_r <= !nvm_crc_ok_i;  // [R3]
            end
        end
    end

    assign sleep_o = (state_r == srs_pkg::SRS_SLEEP);  // [R2]
    assign reload_o = (state_r == srs_pkg::SRS_RELOAD);  // [R3]
    assign nvm_check_o = reload_end;  // [R3]

    // ==========================================================
    // Result registers
    // ==========================================================
    logic [15:0] temp_r;
    logic [15:0] pres_r;
    logic [15:0] ser_lo_r;
    logic [15:0] ser_hi_r;

    // Loads only while running with good memory: a bad checksum freezes both [R6]
    wire res_ok = (state_r == srs_pkg::SRS_RUN) && !crc_bad_r;
    wire temp_load = result_i.temp_load && res_ok;  // [R4]
    wire pres_load = result_i.pres_load && res_ok;  // [R5]
    wire temp_rd = word_rd && (word_addr == srs_pkg::ADDR_TEMP);
    wire pres_rd = word_rd && (word_addr == srs_pkg::ADDR_PRES);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            temp_r <= srs_pkg::RESULT_RESET;
            pres_r <= srs_pkg::RESULT_RESET;
            ser_lo_r <= srs_pkg::SER_RESET;
            ser_hi_r <= srs_pkg::SER_RESET;
        end else begin
            if (temp_load) begin
                temp_r <= result_i.temp_value;  // [R4]
            end
            if (pres_load) begin
                pres_r <= result_i.pres_value;  // [R5]
            end
            // Serial number is latched from configuration memory during reload
            if (state_r == srs_pkg::SRS_RELOAD) begin
                ser_lo_r <= serial_lo_i;  // [R18]
                ser_hi_r <= serial_hi_i;  // [R18]
            end
        end
    end

    assign temperature_o = temp_r;
    assign pressure_o = pres_r;

    // ==========================================================
    // Status flags
    // ==========================================================
    logic [15:0] event_r;
    logic [15:0] event_set;
    logic [15:0] event_clr;
    logic [15:0] live;
    logic [15:0] main_status;
    logic [4:3] copy_r;
    logic [15:0] copy_status;

    always_comb begin
        event_set = 16'h0000;
        event_set[srs_pkg::BIT_TEMP_UP] = temp_load;  // [R4]
        event_set[srs_pkg::BIT_PRES_UP] = pres_load;  // [R5]
        event_set[srs_pkg::BIT_TEMP_MISS] = temp_load && event_r[srs_pkg::BIT_TEMP_UP];  // [R11]
        event_set[srs_pkg::BIT_PRES_MISS] = pres_load && event_r[srs_pkg::BIT_PRES_UP];  // [R11]
        event_set[srs_pkg::BIT_SUPPLY] = cond_i.supply_fail;  // [R13]
        event_set[srs_pkg::BIT_BRIDGE] = cond_i.bridge_fail;  // [R13]
        event_set[srs_pkg::BIT_COM_CRC] = cond_i.com_crc_error;  // [R13]
    end

    always_comb begin
        // Clear by write-one at main status only, never at the copy [R15]
        event_clr = stat_wr ? (wr_word & srs_pkg::EVENT_MASK) : 16'h0000;  // [R15] [R16]
        event_clr[srs_pkg::BIT_TEMP_UP] = event_clr[srs_pkg::BIT_TEMP_UP] || temp_rd;  // [R10]
        event_clr[srs_pkg::BIT_PRES_UP] = event_clr[srs_pkg::BIT_PRES_UP] || pres_rd;  // [R10]
    end

    always_comb begin
        live = 16'h0000;
        live[srs_pkg::BIT_IDLE] = !cond_i.busy && (state_r == srs_pkg::SRS_RUN);  // [R12] [R17]
        live[srs_pkg::BIT_SAT] = cond_i.saturated;  // [R14] [R17]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_r <= 16'h0000;
            copy_r <= 2'b00;
        end else begin
            // Set wins over a clear in the same cycle so no event is lost
            event_r <= ((event_r & ~event_clr) | event_set) & srs_pkg::EVENT_MASK;  // [R23]
            if (temp_rd) begin
                copy_r[srs_pkg::BIT_TEMP_UP] <= event_r[srs_pkg::BIT_TEMP_UP];  // [R9]
            end
            if (pres_rd) begin
                copy_r[srs_pkg::BIT_PRES_UP] <= event_r[srs_pkg::BIT_PRES_UP];  // [R9]
            end
        end
    end

    assign main_status = event_r | live;  // [R23]
    assign copy_status = (main_status & srs_pkg::MIRROR_MASK) | {11'h000, copy_r, 3'h0};  // [R8]

    // ==========================================================
    // Read data
    // ==========================================================
    // Consecutive word addresses from 0x2E give temperature, pressure, copy [R19]
    always_comb begin
        unique case (word_addr)
            srs_pkg::ADDR_TEMP: rd_word = temp_r;  // [R19]
            srs_pkg::ADDR_PRES: rd_word = pres_r;  // [R19]
            srs_pkg::ADDR_COPY: rd_word = copy_status;  // [R19]
            srs_pkg::ADDR_STAT: rd_word = main_status;
            srs_pkg::ADDR_SER_LO: rd_word = ser_lo_r;  // [R18]
            srs_pkg::ADDR_SER_HI: rd_word = ser_hi_r;  // [R18]
            default: rd_word = 16'h0000;
        endcase
    end
endmodule : srs_regs

// file: core/srs_pkg.sv
// Constants and carrier types for the sensor result and status register bank.
// Assumes a byte-level front end that has already removed bus framing and checksums.
//
// Functional notes
// [R1] Only status and command registers accept writes; all others are write protected.
// [R2] Command value 6C32 at 0x22 enters sleep and powers down conditioning.
// [R3] Command value B169 resets and reruns reload plus memory checksum check.
// [R4] Temperature result at 0x2E is read-only; each load sets temperature-updated.
// [R5] Pressure result at 0x30 is read-only; each load sets pressure-updated.
// [R6] Results never update after a configuration memory checksum error.
// [R7] Host waits for both update flags seen set before trusting results; the host model gives up after 50 status reads.
// [R8] Copy bits 15:5 and 0 always equal main status bits.
// [R9] Result reads copy their update flag into copy bits 3 and 4.
// [R10] Reading a result clears its update flag in main status.
// [R11] Update while update flag still set raises missed bit 14 or 15.
// [R12] Status bit 0 reads 1 when idle, 0 when busy.
// [R13] Bits 7, 8, 11 flag supply failure, bridge check failure, bus checksum error.
// [R14] Bit 10 shows saturation of the current result computation.
// [R15] Event flags stay set until written one at 0x36; copy writes ignored.
// [R16] Writing FFFF to main status clears every event flag.
// [R17] Status-type flags follow the live hardware condition.
// [R18] Serial number low word at 0x50, high word at 0x52, read-only.
// [R19] Burst of three words from 0x2E returns temperature, pressure, copy.
// [R20] Accesses are whole words at even addresses.
// [R21] Each word goes low byte first, high byte second, MSB first.
// [R22] Other command values are ignored.
// [R23] Reserved status bits read zero and ignore writes.
package srs_pkg;
    localparam logic [7:0] ADDR_CMD = 8'h22;
    localparam logic [7:0] ADDR_TEMP = 8'h2E;
    localparam logic [7:0] ADDR_PRES = 8'h30;
    localparam logic [7:0] ADDR_COPY = 8'h32;
    localparam logic [7:0] ADDR_STAT = 8'h36;
    localparam logic [7:0] ADDR_SER_LO = 8'h50;
    localparam logic [7:0] ADDR_SER_HI = 8'h52;
    localparam logic [7:0] WORD_STEP = 8'h02;
    localparam logic [15:0] CMD_SLEEP = 16'h6C32;
    localparam logic [15:0] CMD_RESET = 16'hB169;
    localparam logic [15:0] CLEAR_ALL = 16'hFFFF;
    localparam int BIT_IDLE = 0;
    localparam int BIT_PRES_UP = 3;
    localparam int BIT_TEMP_UP = 4;
    localparam int BIT_SUPPLY = 7;
    localparam int BIT_BRIDGE = 8;
    localparam int BIT_SAT = 10;
    localparam int BIT_COM_CRC = 11;
    localparam int BIT_PRES_MISS = 14;
    localparam int BIT_TEMP_MISS = 15;
    // Event bits that software clears by writing one
    localparam logic [15:0] EVENT_MASK = 16'hC998;
    // Bits of the copy that mirror main status live
    localparam logic [15:0] MIRROR_MASK = 16'hFFE1;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] SER_RESET = 16'h0000;
    localparam int RELOAD_CYCLES = 16;

    typedef enum logic [1:0] {
        SRS_RELOAD = 2'b00,
        SRS_RUN = 2'b01,
        SRS_SLEEP = 2'b10
    } srs_power_type;

    // One result load from the measurement datapath
    typedef struct packed {
        logic temp_load;
        logic [15:0] temp_value;
        logic pres_load;
        logic [15:0] pres_value;
    } srs_result_type;

    // Live conditions and one-cycle events from other modules
    typedef struct packed {
        logic busy;
        logic saturated;
        logic supply_fail;
        logic bridge_fail;
        logic com_crc_error;
    } srs_cond_type;
endpackage : srs_pkg

// file: core/srs_word_serdes.sv
// Word to byte sequencer: splits read words and joins written bytes.
// Assumes the bus front end hands one byte per strobe, MSB-first shifting done upstream.
`timescale 1ns/1ps
module srs_word_serdes (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] start_addr_i,
    input wire logic byte_wr_i,
    input wire logic [7:0] wr_byte_i,
    input wire logic byte_rd_i,
    input wire logic [15:0] rd_word_i,
    output logic [7:0] rd_byte_o,
    output logic [7:0] word_addr_o,
    output logic word_wr_o,
    output logic word_rd_o,
    output logic [15:0] wr_word_o
);
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic hi_r;
    logic [7:0] low_r;
    logic [7:0] rd_byte_r;
    logic [7:0] hold_hi_r;

    // Word address stays even whatever the host sent [R20]
    assign addr_nxt = start_i ? {start_addr_i[7:1], 1'b0} : addr_r + srs_pkg::WORD_STEP;
    assign word_addr_o = addr_r;
    // Word moves on the low-byte read and the high-byte write [R21]
    assign word_rd_o = byte_rd_i && !hi_r && !start_i;
    assign word_wr_o = byte_wr_i && hi_r && !start_i;
    assign wr_word_o = {wr_byte_i, low_r};
    assign rd_byte_o = rd_byte_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_r <= 8'h00;
            hi_r <= 1'b0;
            low_r <= 8'h00;
            rd_byte_r <= 8'h00;
            hold_hi_r <= 8'h00;
        end else if (start_i) begin
            addr_r <= addr_nxt;
            hi_r <= 1'b0;
        end else if (byte_wr_i || byte_rd_i) begin
            hi_r <= !hi_r;
            if (byte_wr_i && !hi_r) begin
                low_r <= wr_byte_i;
            end
            if (byte_rd_i && !hi_r) begin
                rd_byte_r <= rd_word_i[7:0];  // [R21]
                hold_hi_r <= rd_word_i[15:8];
            end else if (byte_rd_i) begin
                rd_byte_r <= hold_hi_r;  // [R21]
            end
            if (hi_r) begin
                addr_r <= addr_nxt;
            end
        end
    end
endmodule : srs_word_serdes

// file: dv/srs_regs_asserts.sv
// Checker for the sensor register bank, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module srs_regs_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic byte_rd_i,
    input wire logic [7:0] rd_byte_o,
    input wire srs_pkg::srs_result_type result_i,
    input wire logic reload_done_i,
    input wire logic sleep_o,
    input wire logic reload_o,
    input wire logic nvm_check_o,
    input wire logic [15:0] temperature_o,
    input wire logic [15:0] pressure_o
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_temp_load;
        $changed(temperature_o) && !reload_o |->
            $past(result_i.temp_load) && temperature_o == $past(result_i.temp_value);
    endproperty
    a_temp_load: assert property (p_temp_load) else $error("temperature changed without load");
    property p_pres_load;
        $changed(pressure_o) && !reload_o |->
            $past(result_i.pres_load) && pressure_o == $past(result_i.pres_value);
    endproperty
    a_pres_load: assert property (p_pres_load) else $error("pressure changed without load");
    property p_frozen;
        (reload_o || sleep_o) && (result_i.temp_load || result_i.pres_load) |=>
            $stable(temperature_o) && $stable(pressure_o);
    endproperty
    a_frozen: assert property (p_frozen) else $error("result loaded outside run");
    property p_check_end;
        nvm_check_o |-> reload_o ##1 !reload_o;
    endproperty
    a_check_end: assert property (p_check_end) else $error("memory check not at reload end");
    property p_reload_min;
        $rose(reload_o) |-> reload_o [*8];
    endproperty
    a_reload_min: assert property (p_reload_min) else $error("reload too short");
    property p_reload_wait;
        reload_o && !reload_done_i |=> reload_o;
    endproperty
    a_reload_wait: assert property (p_reload_wait) else $error("reload left before loader done");
    property p_sleep_hold;
        sleep_o |=> (sleep_o || reload_o) && !(sleep_o && reload_o);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without reset");
    property p_read_byte;
        $changed(rd_byte_o) |-> $past(byte_rd_i);
    endproperty
    a_read_byte: assert property (p_read_byte) else $error("read byte moved without strobe");
endmodule : srs_regs_asserts

bind srs_regs srs_regs_asserts u_srs_regs_asserts (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .byte_rd_i(byte_rd_i),
    .rd_byte_o(rd_byte_o),
    .result_i(result_i),
    .reload_done_i(reload_done_i),
    .sleep_o(sleep_o),
    .reload_o(reload_o),
    .nvm_check_o(nvm_check_o),
    .temperature_o(temperature_o),
    .pressure_o(pressure_o)
);

// file: dv/srs_host_model.sv
// Bus host model: word reads and writes over the byte strobe interface.
// Assumes the bench calls its tasks in sequence; strobes move at falling edges.
`timescale 1ns/1ps
module srs_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rd_byte_i,
    output logic start_o,
    output logic [7:0] start_addr_o,
    output logic byte_wr_o,
    output logic [7:0] wr_byte_o,
    output logic byte_rd_o
);
    // ==========================================================
    // Bus cycles
    logic [15:0] rq [0:2];
    initial begin
        start_o = 1'h0;
        start_addr_o = 8'h00;
        byte_wr_o = 1'h0;
        wr_byte_o = 8'h00;
        byte_rd_o = 1'h0;
    end
    // Idle data toggles so a stale byte can never pass for a written one
    task automatic drive(input logic s, input logic w, input logic r, input logic [7:0] a,
                         input logic [7:0] v);
        @(negedge clk_i);
        start_o = s;
        start_addr_o = a;
        byte_wr_o = w;
        byte_rd_o = r;
        wr_byte_o = w ? v : ~wr_byte_o;
    endtask : drive
    task automatic read_seq(input logic [7:0] a, input int n);
        drive(1'h1, 1'h0, 1'h0, a & 8'hFE, 8'h00);
        for (int i = 0; i < n; i++) begin
            drive(1'h0, 1'h0, 1'h1, start_addr_o, 8'h00);
            if (i > 0) rq[i - 1][15:8] = rd_byte_i;
            drive(1'h0, 1'h0, 1'h1, start_addr_o, 8'h00);
            rq[i][7:0] = rd_byte_i;
        end
        drive(1'h0, 1'h0, 1'h0, start_addr_o, 8'h00);
        rq[n - 1][15:8] = rd_byte_i;
    endtask : read_seq
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        drive(1'h1, 1'h0, 1'h0, a & 8'hFE, 8'h00);
        drive(1'h0, 1'h1, 1'h0, start_addr_o, d[7:0]);
        drive(1'h0, 1'h1, 1'h0, start_addr_o, d[15:8]);
        drive(1'h0, 1'h0, 1'h0, start_addr_o, 8'h00);
        drive(1'h0, 1'h0, 1'h0, start_addr_o, 8'h00);
    endtask : write_word
    // Results are trusted once both update flags were seen, or after 50 status reads without them
    task automatic wait_fresh();
        logic [1:0] seen;
        seen = 2'h0;
        for (int k = 0; k < 50 && seen != 2'h3; k++) begin
            read_seq(srs_pkg::ADDR_STAT, 1);
            seen = seen | rq[0][4:3];
        end
    endtask : wait_fresh
endmodule : srs_host_model

// file: dv/test_srs_regs.sv
// Self-checking bench for the sensor register bank.
// Assumes the checker is bound by its own file; host model drives the bus.
`timescale 1ns/1ps
module test_srs_regs;
    // ==========================================================
    // Signals and instances
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    srs_pkg::srs_result_type result_i = '0;
    srs_pkg::srs_cond_type cond_i = '0;
    logic nvm_crc_ok_i = 1'h1;
    logic reload_done_i = 1'h0;
    logic [15:0] serial_lo_i = 16'h1A2B;
    logic [15:0] serial_hi_i = 16'h3C4D;
    logic start, byte_wr, byte_rd, sleep_o, reload_o, nvm_check_o;
    logic [7:0] start_addr, wr_byte, rd_byte;
    logic [15:0] temperature_o, pressure_o, pulses;
    int fail_count = 0;
    int samples_checked = 0;
    srs_regs u_srs_regs (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
        .start_addr_i(start_addr), .byte_wr_i(byte_wr), .wr_byte_i(wr_byte),
        .byte_rd_i(byte_rd), .rd_byte_o(rd_byte), .result_i(result_i), .cond_i(cond_i),
        .nvm_crc_ok_i(nvm_crc_ok_i), .reload_done_i(reload_done_i),
        .serial_lo_i(serial_lo_i), .serial_hi_i(serial_hi_i), .sleep_o(sleep_o),
        .reload_o(reload_o), .nvm_check_o(nvm_check_o), .temperature_o(temperature_o),
        .pressure_o(pressure_o));
    srs_host_model u_host (.clk_i(clk_i), .rd_byte_i(rd_byte), .start_o(start),
        .start_addr_o(start_addr), .byte_wr_o(byte_wr), .wr_byte_o(wr_byte),
        .byte_rd_o(byte_rd));
    initial forever #2 clk_i = ~clk_i;
    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic load(input logic t, input logic [15:0] tv, input logic p, input logic [15:0] pv);
        @(negedge clk_i);
        result_i = '{t, tv, p, pv};
        @(negedge clk_i);
        result_i = '0;
    endtask : load
    task automatic rd_check(input string what, input logic [7:0] a, input logic [15:0] exp);
        u_host.read_seq(a, 1);
        check(what, exp, u_host.rq[0]);
    endtask : rd_check
    // Counts memory check pulses seen at falling edges while the reload lasts
    task automatic wait_run(output logic [15:0] pulses);
        pulses = 16'h0000;
        for (int i = 0; i < 100 && reload_o !== 1'h0; i++) begin
            if (nvm_check_o === 1'h1) pulses++;
            @(negedge clk_i);
        end
    endtask : wait_run
    // ==========================================================
    // Tests
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        rst_i = 1'h0;
        repeat (20) @(negedge clk_i);
        check("reload_wait", 16'h0001, {15'h0, reload_o});
        reload_done_i = 1'h1;
        wait_run(pulses);
        check("reload_end", 16'h0000, {15'h0, reload_o});
        rd_check("ser_lo", srs_pkg::ADDR_SER_LO, 16'h1A2B);
        rd_check("ser_hi", srs_pkg::ADDR_SER_HI, 16'h3C4D);
        u_host.write_word(srs_pkg::ADDR_SER_LO, 16'h5555);
        u_host.write_word(srs_pkg::ADDR_TEMP, 16'h5555);
        rd_check("ser_prot", srs_pkg::ADDR_SER_LO, 16'h1A2B);
        rd_check("temp_prot", srs_pkg::ADDR_TEMP, 16'h0000);
        rd_check("idle", srs_pkg::ADDR_STAT, 16'h0001);
        load(1'h1, 16'h7DF2, 1'h1, 16'h82EA);
        u_host.wait_fresh();
        rd_check("up_set", srs_pkg::ADDR_STAT, 16'h0019);
        u_host.read_seq(srs_pkg::ADDR_TEMP, 3);
        check("burst_t", 16'h7DF2, u_host.rq[0]);
        check("burst_p", 16'h82EA, u_host.rq[1]);
        check("burst_copy", 16'h0019, u_host.rq[2]);
        rd_check("up_clr", srs_pkg::ADDR_STAT, 16'h0001);
        u_host.read_seq(srs_pkg::ADDR_TEMP, 3);
        check("copy_stale", 16'h0001, u_host.rq[2]);
        load(1'h1, 16'h1111, 1'h1, 16'h2222);
        load(1'h1, 16'h3333, 1'h1, 16'h4444);
        check("temp_out", 16'h3333, temperature_o);
        cond_i = 5'h0F;
        @(negedge clk_i);
        cond_i = 5'h08;
        rd_check("events", srs_pkg::ADDR_STAT, 16'hCD99);
        rd_check("mirror", srs_pkg::ADDR_COPY, 16'hCD81);
        u_host.write_word(srs_pkg::ADDR_COPY, 16'hFFFF);
        rd_check("copy_wr", srs_pkg::ADDR_STAT, 16'hCD99);
        u_host.write_word(srs_pkg::ADDR_STAT, 16'h0080);
        rd_check("one_clr", srs_pkg::ADDR_STAT, 16'hCD19);
        u_host.write_word(srs_pkg::ADDR_STAT, srs_pkg::CLEAR_ALL);
        rd_check("all_clr", srs_pkg::ADDR_STAT, 16'h0401);
        cond_i = 5'h10;
        rd_check("busy", srs_pkg::ADDR_STAT, 16'h0000);
        cond_i = 5'h00;
        u_host.write_word(srs_pkg::ADDR_CMD, 16'h1234);
        check("odd_cmd", 16'h0000, {14'h0, sleep_o, reload_o});
        u_host.write_word(srs_pkg::ADDR_CMD, srs_pkg::CMD_SLEEP);
        check("sleep", 16'h0002, {14'h0, sleep_o, reload_o});
        load(1'h1, 16'h0BAD, 1'h1, 16'h0BAD);
        check("sleep_frz", 16'h3333, temperature_o);
        nvm_crc_ok_i = 1'h0;
        u_host.write_word(srs_pkg::ADDR_CMD, srs_pkg::CMD_RESET);
        check("reset_cmd", 16'h0001, {14'h0, sleep_o, reload_o});
        wait_run(pulses);
        check("nvm_check", 16'h0001, pulses);
        load(1'h1, 16'h0BAD, 1'h1, 16'h0BAD);
        check("frozen", 16'h4444, pressure_o);
        check("frozen_t", 16'h3333, temperature_o);
        rd_check("no_up", srs_pkg::ADDR_STAT, 16'h0001);
        print_verdict();
    end
endmodule : test_srs_regs
